// file: clock_sync_codec.v
// clock synchronization server and client for one link port
`timescale 1ns/1ps
`include "clock_sync_consts.vh"

module clock_sync_codec (
   mclk,
   reset_n,
   server_enable,
   client_enable,
   method_els,
   coding_64b66b,
   period_wr,
   period_value,
   csr_accept,
   csu_rx_valid,
   csu_rx_time,
   tx_in_word,
   tx_in_k,
   tx_in_fill,
   rx_word,
   rx_k,
   rx_fill,
   tx_word,
   tx_k,
   csu_tx_req,
   csu_tx_time,
   csr_notify,
   cap_server,
   cap_client,
   client_time,
   client_loaded,
   rx_fill_out
);
   input  wire                  mclk;
   input  wire                  reset_n;
   input  wire                  server_enable;
   input  wire                  client_enable;
   input  wire                  method_els;
   input  wire                  coding_64b66b;
   input  wire                  period_wr;
   input  wire [`PERIOD_W-1:0]  period_value;
   input  wire                  csr_accept;
   input  wire                  csu_rx_valid;
   input  wire [`TIME_W-1:0]    csu_rx_time;
   input  wire [31:0]           tx_in_word;
   input  wire [3:0]            tx_in_k;
   input  wire                  tx_in_fill;
   input  wire [31:0]           rx_word;
   input  wire [3:0]            rx_k;
   input  wire                  rx_fill;
   output reg  [31:0]           tx_word;
   output reg  [3:0]            tx_k;
   output reg                   csu_tx_req;
   output reg  [`TIME_W-1:0]    csu_tx_time;
   output reg                   csr_notify;
   output reg                   cap_server;
   output reg                   cap_client;
   output reg  [`TIME_W-1:0]    client_time;
   output reg                   client_loaded;
   output reg                   rx_fill_out;

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_Y    = 3'h2;
   localparam [2:0] ST_Z    = 3'h4;
   // ********************
   // reset release
   // ********************
   reg rst_meta_reg;
   reg rst_n_reg;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end
   // ********************
   // microsecond tick, master counter and event period
   // ********************
   reg  [`US_DIV_W-1:0]  div_reg;
   reg                   tick_reg;
   reg  [`MASTER_W-1:0]  master_reg;
   reg  [`PERIOD_W-1:0]  period_reg;
   reg  [`PERIOD_W-1:0]  per_cnt_reg;
   reg                   pend_reg;
   wire [`TIME_W-1:0]    time_ext = {{(`TIME_W-`MASTER_W){1'b0}}, master_reg};
   wire [`PERIOD_W-1:0]  per_next = per_cnt_reg + 26'h0000001;
   wire                  prim_ok  = server_enable && !method_els && !coding_64b66b;
   wire                  ev_due   = tick_reg && server_enable && period_reg != 26'h0000000
                                    && per_next >= period_reg;
   wire                  start;
   always @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         div_reg     <= 7'h00;
         tick_reg    <= 1'b0;
         master_reg  <= 32'h00000000;
         period_reg  <= `PERIOD_DEFAULT_US;
         per_cnt_reg <= 26'h0000000;
         pend_reg    <= 1'b0;
         csu_tx_req  <= 1'b0;
         csu_tx_time <= 42'h00000000000;
         csr_notify  <= 1'b0;
         cap_server  <= 1'b0;
         cap_client  <= 1'b0;
      end else begin
         div_reg  <= (div_reg == `US_DIV_LAST) ? 7'h00 : div_reg + 7'h01;
         tick_reg <= (div_reg == `US_DIV_LAST);
         if (tick_reg)
            master_reg <= master_reg + 32'h00000001;
         if (period_wr)
            period_reg <= period_value;
         if (ev_due || !server_enable || period_reg == 26'h0000000)
            per_cnt_reg <= 26'h0000000;
         else if (tick_reg)
            per_cnt_reg <= per_next;
         csu_tx_req <= ev_due && method_els;
         if (ev_due && method_els)
            csu_tx_time <= time_ext;
         // a new event wins over the clear made by the insertion in the same cycle
         if (ev_due && prim_ok)
            pend_reg <= 1'b1;
         else if (start || !prim_ok)
            pend_reg <= 1'b0;
         csr_notify <= csr_accept && server_enable;
         cap_server <= server_enable;
         cap_client <= client_enable;
      end
   end
   // ********************
   // transmit: lookahead line and sync set insertion
   // ********************
   // five words of delay let us see that two fills follow the three replaced ones
   reg [36:0] pipe_reg [0:`LOOKAHEAD-1];
   reg [2:0]  tx_state_reg;
   reg [1:0]  fill_run_reg;
   reg [`TIME_W-1:0] snap_reg;
   reg [13:0] enc_in;
   wire [15:0] enc_out;
   wire [13:0] dec_out;
   wire [1:0]  dec_valid;
   wire        ahead_fill;
   wire [36:0] pipe_out = pipe_reg[`LOOKAHEAD-1];
   integer     s;
   genvar g;
   generate
      for (g = 0; g < `LOOKAHEAD; g = g + 1) begin : look
         wire is_fill = pipe_reg[g][36];
         wire chain;
         if (g == 0) begin : first
            assign chain = is_fill;
         end else begin : rest
            assign chain = is_fill && look[g-1].chain;
         end
      end
   endgenerate
   assign ahead_fill = look[`LOOKAHEAD-1].chain;
   always @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         for (s = 0; s < `LOOKAHEAD; s = s + 1)
            pipe_reg[s] <= 37'h0000000000;
      end else begin
         pipe_reg[0] <= {tx_in_fill, tx_in_k, tx_in_word};
         for (s = 1; s < `LOOKAHEAD; s = s + 1)
            pipe_reg[s] <= pipe_reg[s-1];
      end
   end
   assign start = (tx_state_reg == ST_IDLE) && pend_reg && prim_ok
                  && fill_run_reg == `FILL_GUARD && ahead_fill;
   always @* begin
      case (tx_state_reg)
         ST_Y:    enc_in = snap_reg[`SEGY_LSB+`SEG_W-1:`SEGY_LSB];
         ST_Z:    enc_in = snap_reg[`SEGZ_LSB+`SEG_W-1:`SEGZ_LSB];
         default: enc_in = time_ext[`SEGX_LSB+`SEG_W-1:`SEGX_LSB];
      endcase
   end
   nd_char_codec codec (
      .enc_in    ({enc_in[6:0], enc_in[13:7]}),
      .enc_out   (enc_out),
      .dec_in    (rx_word[15:0]),
      .dec_out   (dec_out),
      .dec_valid (dec_valid)
   );
   always @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         tx_state_reg <= ST_IDLE;
         fill_run_reg <= 2'h0;
         snap_reg     <= 42'h00000000000;
         tx_word      <= 32'h00000000;
         tx_k         <= 4'h0;
      end else begin
         case (tx_state_reg)
            ST_IDLE: begin
               if (start) begin
                  snap_reg     <= time_ext;
                  tx_word      <= {`SYN_K_CHAR, `SYNX_ID, enc_out[7:0], enc_out[15:8]};
                  tx_k         <= `SYN_K_MASK;
                  tx_state_reg <= ST_Y;
                  fill_run_reg <= 2'h0;
               end else begin
                  tx_word <= pipe_out[31:0];
                  tx_k    <= pipe_out[35:32];
                  if (!pipe_out[36])
                     fill_run_reg <= 2'h0;
                  else if (fill_run_reg != `FILL_GUARD)
                     fill_run_reg <= fill_run_reg + 2'h1;
               end
            end
            ST_Y: begin
               tx_word      <= {`SYN_K_CHAR, `SYNY_ID, enc_out[7:0], enc_out[15:8]};
               tx_k         <= `SYN_K_MASK;
               tx_state_reg <= ST_Z;
            end
            ST_Z: begin
               tx_word      <= {`SYN_K_CHAR, `SYNZ_ID, enc_out[7:0], enc_out[15:8]};
               tx_k         <= `SYN_K_MASK;
               tx_state_reg <= ST_IDLE;
            end
            default: tx_state_reg <= ST_IDLE;
         endcase
      end
   end

   // ********************
   // receive: sync set recognition and client counter
   // ********************
   reg  [2:0]  rx_state_reg;
   reg  [27:0] rx_part_reg;
   wire        rx_syn  = rx_k == `SYN_K_MASK && rx_word[31:24] == `SYN_K_CHAR && (&dec_valid);
   wire        rx_x    = rx_syn && rx_word[23:16] == `SYNX_ID;
   wire        rx_y    = rx_syn && rx_word[23:16] == `SYNY_ID;
   wire        rx_z    = rx_syn && rx_word[23:16] == `SYNZ_ID;
   wire [13:0] rx_grp  = {dec_out[13:7], dec_out[6:0]};
   wire        rx_load = rx_z && rx_state_reg == ST_Z && client_enable && !coding_64b66b;
   always @(posedge mclk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rx_state_reg  <= ST_IDLE;
         rx_part_reg   <= 28'h0000000;
         client_time   <= 42'h00000000000;
         client_loaded <= 1'b0;
         rx_fill_out   <= 1'b0;
      end else begin
         // sync sets pass on as fill words whether or not the client uses them
         rx_fill_out <= rx_fill || rx_x || rx_y || rx_z;
         case (rx_state_reg)
            ST_Y: begin
               rx_state_reg <= rx_y ? ST_Z : (rx_x ? ST_Y : ST_IDLE);
               if (rx_y)
                  rx_part_reg[13:0] <= rx_grp;
               else if (rx_x)
                  rx_part_reg[27:14] <= rx_grp;
            end
            ST_Z: begin
               rx_state_reg <= rx_x ? ST_Y : ST_IDLE;
               if (rx_x)
                  rx_part_reg[27:14] <= rx_grp;
            end
            default: begin
               rx_state_reg <= rx_x ? ST_Y : ST_IDLE;
               if (rx_x)
                  rx_part_reg[27:14] <= rx_grp;
            end
         endcase
         client_loaded <= rx_load || (csu_rx_valid && client_enable);
         if (rx_load)
            client_time <= {rx_part_reg, rx_grp};
         else if (csu_rx_valid && client_enable)
            client_time <= csu_rx_time;
         else if (tick_reg)
            client_time <= client_time + 42'h00000000001;
      end
   end
endmodule // clock_sync_codec

// file: clock_sync_consts.vh
// constants for the clock synchronization codec
`ifndef CLOCK_SYNC_CONSTS_VH
`define CLOCK_SYNC_CONSTS_VH

// ********************
// timing
// ********************
`define CLK_PERIOD_NS      10
`define US_NS              1000
`define US_CYCLES          (`US_NS / `CLK_PERIOD_NS)
`define US_DIV_W           7
`define US_DIV_LAST        7'h63
`define PERIOD_W           26
`define PERIOD_DEFAULT_US  26'h00F4240

// ********************
// widths and fields
// ********************
`define MASTER_W           32
`define TIME_W             42
`define GROUP_W            7
`define SEG_W              14
`define SEGX_LSB           28
`define SEGY_LSB           14
`define SEGZ_LSB           0

// ********************
// ordered set layout: {k char, set id, group1 char, group2 char}
// ********************
`define SYN_K_CHAR         8'hBC
`define SYN_K_MASK         4'h8
`define SYNX_ID            8'hB5
`define SYNY_ID            8'hB6
`define SYNZ_ID            8'hB7
`define FILL_GUARD         2'h2
`define LOOKAHEAD          5

`endif

// file: nd_char_codec.v
// two-lane mapping between 7-bit groups and neutral-disparity data characters
`timescale 1ns/1ps
module nd_char_codec (
   enc_in,
   enc_out,
   dec_in,
   dec_out,
   dec_valid
);
   input  wire [13:0] enc_in;
   output wire [15:0] enc_out;
   input  wire [15:0] dec_in;
   output wire [13:0] dec_out;
   output wire [1:0]  dec_valid;

   // rows that hold three characters (x coded as low five bits)
   function [4:0] a_row;
      input [3:0] i;
      case (i)
         4'h0: a_row = 5'h00;  4'h1: a_row = 5'h01;  4'h2: a_row = 5'h02;  4'h3: a_row = 5'h04;
         4'h4: a_row = 5'h08;  4'h5: a_row = 5'h0F;  4'h6: a_row = 5'h10;  4'h7: a_row = 5'h17;
         4'h8: a_row = 5'h18;  4'h9: a_row = 5'h1B;  4'hA: a_row = 5'h1D;  4'hB: a_row = 5'h1E;
         default: a_row = 5'h1F;
      endcase
   endfunction

   // rows that hold five characters
   function [4:0] b_row;
      input [4:0] i;
      case (i)
         5'h00: b_row = 5'h03;  5'h01: b_row = 5'h05;  5'h02: b_row = 5'h06;  5'h03: b_row = 5'h07;
         5'h04: b_row = 5'h09;  5'h05: b_row = 5'h0A;  5'h06: b_row = 5'h0B;  5'h07: b_row = 5'h0C;
         5'h08: b_row = 5'h0D;  5'h09: b_row = 5'h0E;  5'h0A: b_row = 5'h11;  5'h0B: b_row = 5'h12;
         5'h0C: b_row = 5'h13;  5'h0D: b_row = 5'h14;  5'h0E: b_row = 5'h15;  5'h0F: b_row = 5'h16;
         5'h10: b_row = 5'h19;  5'h11: b_row = 5'h1A;  default: b_row = 5'h1C;
      endcase
   endfunction

   // group value to character, ordinal equals value
   function [7:0] encode;
      input [6:0] v;
      reg   [6:0] d;
      begin
         d = 7'h00;
         if (v <= 7'd5) begin
            d = 7'd5 - v;
            encode = {3'h7, a_row(d[3:0])};
         end else if (v <= 7'd24) begin
            d = 7'd24 - v;
            encode = {3'h6, b_row(d[4:0])};
         end else if (v <= 7'd43) begin
            d = 7'd43 - v;
            encode = {3'h5, b_row(d[4:0])};
         end else if (v <= 7'd56) begin
            d = 7'd56 - v;
            encode = {3'h4, a_row(d[3:0])};
         end else if (v <= 7'd75) begin
            d = 7'd75 - v;
            encode = {3'h3, b_row(d[4:0])};
         end else if (v <= 7'd94) begin
            d = 7'd94 - v;
            encode = {3'h2, b_row(d[4:0])};
         end else if (v <= 7'd113) begin
            d = 7'd113 - v;
            encode = {3'h1, b_row(d[4:0])};
         end else if (v <= 7'd126) begin
            d = 7'd126 - v;
            encode = {3'h0, a_row(d[3:0])};
         end else begin
            encode = 8'hFF;
         end
      end
   endfunction

   // character to {valid, ordinal}; ordinals above 127 and non-neutral characters are invalid
   function [7:0] decode;
      input [7:0] c;
      reg   [4:0] ai;
      reg   [5:0] bi;
      reg   [4:0] k;
      begin
         ai = 5'h00;
         bi = 6'h00;
         for (k = 5'h00; k < 5'h13; k = k + 5'h01) begin
            if (k < 5'h0D && a_row(k[3:0]) == c[4:0])
               ai = {1'b1, k[3:0]};
            if (b_row(k) == c[4:0])
               bi = {1'b1, k};
         end
         case (c[7:5])
            3'h7: decode = (ai[4] && ai[3:0] <= 4'h5) ? {1'b1, 7'd5 - {3'h0, ai[3:0]}} :
                           (ai[4] && ai[3:0] == 4'hC) ? 8'hFF : 8'h00;
            3'h6: decode = bi[5] ? {1'b1, 7'd24 - {2'h0, bi[4:0]}} : 8'h00;
            3'h5: decode = bi[5] ? {1'b1, 7'd43 - {2'h0, bi[4:0]}} : 8'h00;
            3'h4: decode = ai[4] ? {1'b1, 7'd56 - {3'h0, ai[3:0]}} : 8'h00;
            3'h3: decode = bi[5] ? {1'b1, 7'd75 - {2'h0, bi[4:0]}} : 8'h00;
            3'h2: decode = bi[5] ? {1'b1, 7'd94 - {2'h0, bi[4:0]}} : 8'h00;
            3'h1: decode = bi[5] ? {1'b1, 7'd113 - {2'h0, bi[4:0]}} : 8'h00;
            default: decode = ai[4] ? {1'b1, 7'd126 - {3'h0, ai[3:0]}} : 8'h00;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : lane
         wire [7:0] dec_w;
         assign enc_out[8*g+7:8*g]   = encode(enc_in[7*g+6:7*g]);
         assign dec_w                = decode(dec_in[8*g+7:8*g]);
         assign dec_out[7*g+6:7*g]   = dec_w[6:0];
         assign dec_valid[g]         = dec_w[7];
      end
   endgenerate
endmodule // nd_char_codec

// file: link_peer.sv
// far-end link port model: sends fill words and clock sync sets into the receive stream
`timescale 1ns/1ps
`include "clock_sync_consts.vh"
module link_peer (
   mclk,
   rx_word,
   rx_k,
   rx_fill
);
   input  wire        mclk;
   output reg  [31:0] rx_word;
   output reg  [3:0]  rx_k;
   output reg         rx_fill;
   localparam [31:0] fill_word = 32'hBC95B5B5;
   // bit x set: row x holds characters in columns 0, 4 and 7
   localparam [31:0] a_rows    = 32'hE9818117;
   initial begin
      rx_word = fill_word;
      rx_k    = 4'h8;
      rx_fill = 1'b1;
   end
   // character whose ordinal equals the group value
   function [7:0] nd_char(input [6:0] v);
      integer y, x, ia, ib, ord;
      begin
         nd_char = 8'h00;
         for (y = 0; y < 8; y = y + 1) begin
            ia = 0;
            ib = 0;
            for (x = 0; x < 32; x = x + 1) begin
               if (a_rows[x]) begin
                  case (y)
                     0: ord = 126 - ia;
                     4: ord = 56 - ia;
                     7: ord = (ia < 6) ? 5 - ia : 139 - ia;
                     default: ord = -1;
                  endcase
                  ia = ia + 1;
               end else begin
                  case (y)
                     1: ord = 113 - ib;
                     2: ord = 94 - ib;
                     3: ord = 75 - ib;
                     5: ord = 43 - ib;
                     6: ord = 24 - ib;
                     default: ord = -1;
                  endcase
                  ib = ib + 1;
               end
               if (ord == v) nd_char = {y[2:0], x[4:0]};
            end
         end
      end
   endfunction
   // slow inverse: 0 for a character that has no ordinal
   function [6:0] nd_ord(input [7:0] c);
      integer v;
      begin
         nd_ord = 7'h00;
         for (v = 0; v < 128; v = v + 1) if (nd_char(v[6:0]) == c) nd_ord = v[6:0];
      end
   endfunction
   task put(input [7:0] id, input [13:0] g, input bad);
      begin
         // 03h is no neutral character, so a bad set is unrecognisable
         rx_word = {`SYN_K_CHAR, id, bad ? 8'h03 : nd_char(g[13:7]), nd_char(g[6:0])};
         rx_k    = `SYN_K_MASK;
         rx_fill = 1'b0;
      end
   endtask
   task idle;
      begin
         rx_word = fill_word;
         rx_k    = 4'h8;
         rx_fill = 1'b1;
      end
   endtask
   // mode 1 breaks the set with a fill, mode 2 corrupts one character
   task send_set(input [41:0] t, input [1:0] m);
      begin
         // direct link with no fabric between, so there is no transit delay to correct
         @(negedge mclk) put(`SYNX_ID, t[41:28], m == 2'h2);
         @(negedge mclk) put(`SYNY_ID, t[27:14], 1'b0);
         if (m == 2'h1) @(negedge mclk) idle;
         @(negedge mclk) put(`SYNZ_ID, t[13:0], 1'b0);
         @(negedge mclk) idle;
      end
   endtask
endmodule // link_peer

// file: clock_sync_codec_props.sv
// concurrent checks on the clock sync codec ports
`timescale 1ns/1ps
`include "clock_sync_consts.vh"
module clock_sync_codec_props (
   mclk,
   reset_n,
   server_enable,
   client_enable,
   method_els,
   coding_64b66b,
   csr_accept,
   tx_in_fill,
   rx_word,
   rx_k,
   rx_fill,
   tx_word,
   tx_k,
   csu_tx_req,
   csu_tx_time,
   csr_notify,
   cap_server,
   cap_client,
   client_loaded,
   rx_fill_out
);
   input wire               mclk;
   input wire               reset_n;
   input wire               server_enable;
   input wire               client_enable;
   input wire               method_els;
   input wire               coding_64b66b;
   input wire               csr_accept;
   input wire               tx_in_fill;
   input wire [31:0]        rx_word;
   input wire [3:0]         rx_k;
   input wire               rx_fill;
   input wire [31:0]        tx_word;
   input wire [3:0]         tx_k;
   input wire               csu_tx_req;
   input wire [`TIME_W-1:0] csu_tx_time;
   input wire               csr_notify;
   input wire               cap_server;
   input wire               cap_client;
   input wire               client_loaded;
   input wire               rx_fill_out;
   // internal reset trails reset_n by two edges, so checks wait a little longer
   reg  [1:0] live_reg;
   wire       live = (live_reg == 2'h3);
   wire       syn_x = (tx_k == `SYN_K_MASK) && (tx_word[31:16] == {`SYN_K_CHAR, `SYNX_ID});
   wire       syn_y = (tx_k == `SYN_K_MASK) && (tx_word[31:16] == {`SYN_K_CHAR, `SYNY_ID});
   wire       syn_z = (tx_k == `SYN_K_MASK) && (tx_word[31:16] == {`SYN_K_CHAR, `SYNZ_ID});
   wire       rx_y = (rx_k == `SYN_K_MASK) && (rx_word[31:16] == {`SYN_K_CHAR, `SYNY_ID});
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) live_reg <= 2'h0;
      else if (!live) live_reg <= live_reg + 2'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!live);
   a_notify_on_accept: assert property (csr_accept && server_enable |=> csr_notify)
      else $error("notify missing after accept");
   a_notify_has_cause: assert property (csr_notify |-> $past(csr_accept) && $past(server_enable))
      else $error("notify without accept");
   a_cap_bits_follow: assert property (##1 cap_server == $past(server_enable) && cap_client == $past(client_enable))
      else $error("capability bit wrong");
   a_req_one_cycle: assert property (csu_tx_req |=> !csu_tx_req)
      else $error("update request longer than one cycle");
   a_req_from_server: assert property (csu_tx_req |-> $past(server_enable) && $past(method_els))
      else $error("update request while not command server");
   a_time_zero_top: assert property (csu_tx_time[41:32] == 10'h000)
      else $error("update time not zero extended");
   a_syn_three_seq: assert property (syn_x |=> syn_y ##1 syn_z)
      else $error("sync sets not back to back");
   a_syn_top_group: assert property (syn_x |-> tx_word[15:8] == 8'hEF)
      else $error("top group char not zero");
   a_syn_fill_guard: assert property (syn_x |-> ##4 ($past(tx_in_fill, 6) && $past(tx_in_fill, 7) && $past(tx_in_fill, 8)
      && $past(tx_in_fill, 9) && $past(tx_in_fill, 10) && $past(tx_in_fill, 11) && $past(tx_in_fill, 12)))
      else $error("sync sets not bracketed by fills");
   a_syn_off_64b: assert property (coding_64b66b && $past(coding_64b66b, 8) |-> !syn_x)
      else $error("sync set sent on 64b66b port");
   a_rx_fill_seen: assert property (rx_fill || rx_y |=> rx_fill_out)
      else $error("fill or sync set not reported as fill");
   a_load_needs_en: assert property (client_loaded |-> $past(client_enable))
      else $error("load while client disabled");
   c_syn_sent: cover property (syn_x ##2 syn_z);
   c_req_sent: cover property (csu_tx_req);
   c_loaded: cover property (client_loaded);
   c_notify: cover property (csr_notify);
endmodule // clock_sync_codec_props

// file: clock_sync_codec_tb.sv
// self-checking bench for the clock sync codec
`timescale 1ns/1ps
`include "clock_sync_consts.vh"
module clock_sync_codec_tb;
   reg                  mclk = 0, reset_n = 0, server_enable = 0, client_enable = 0, method_els = 0;
   reg                  coding_64b66b = 0, period_wr = 0, csr_accept = 0, csu_rx_valid = 0, tx_in_fill = 1;
   reg  [`PERIOD_W-1:0] period_value = 0;
   reg  [`TIME_W-1:0]   csu_rx_time = 0, last_req = 0, last_syn = 0, t = 0;
   reg  [31:0]          tx_in_word = 32'hBC95B5B5, h1 = 0, h2 = 0;
   reg  [3:0]           tx_in_k = 4'h8;
   reg  [47:0]          w;
   reg  [179:0]         hist;
   reg  [6:0]           g;
   wire [31:0]          rx_word, tx_word;
   wire [3:0]           rx_k, tx_k;
   wire                 rx_fill, csu_tx_req, csr_notify, cap_server, cap_client, client_loaded, rx_fill_out;
   wire [`TIME_W-1:0]   csu_tx_time, client_time;
   reg  [`TIME_W-1:0]   exp_q[$];
   integer              seed = 4030, fail_count = 0, cmp_count = 0, req_cnt = 0, syn_cnt = 0, pos = 0;
   integer              exp_diff = 0, n, i, k;
   reg                  have_req = 0, short_gaps = 0;
   always #5 mclk = ~mclk;
   clock_sync_codec DUT (.mclk(mclk), .reset_n(reset_n), .server_enable(server_enable),
      .client_enable(client_enable), .method_els(method_els), .coding_64b66b(coding_64b66b),
      .period_wr(period_wr), .period_value(period_value), .csr_accept(csr_accept), .csu_rx_valid(csu_rx_valid),
      .csu_rx_time(csu_rx_time), .tx_in_word(tx_in_word), .tx_in_k(tx_in_k), .tx_in_fill(tx_in_fill),
      .rx_word(rx_word), .rx_k(rx_k), .rx_fill(rx_fill), .tx_word(tx_word), .tx_k(tx_k), .csu_tx_req(csu_tx_req),
      .csu_tx_time(csu_tx_time), .csr_notify(csr_notify), .cap_server(cap_server), .cap_client(cap_client),
      .client_time(client_time), .client_loaded(client_loaded), .rx_fill_out(rx_fill_out));
   link_peer u_peer (.mclk(mclk), .rx_word(rx_word), .rx_k(rx_k), .rx_fill(rx_fill));
   task check(input [63:0] got, input [63:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
         if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // which = 0 waits for update requests, 1 for sent sync sets
   task wait_until(input integer which, input integer cnt);
      begin
         for (k = 0; k < 3000 && ((which ? syn_cnt : req_cnt) < cnt); k = k + 1) @(negedge mclk);
         if (k == 3000) begin
            fail_count = fail_count + 1;
            final_report;
         end
      end
   endtask
   task set_period(input [`PERIOD_W-1:0] p);
      begin
         period_value = p;
         period_wr = 1'b1;
         @(negedge mclk) period_wr = 1'b0;
         have_req = 0;
         exp_diff = p;
      end
   endtask
   // outgoing stream: all fills, or gaps of six fills that can never hold a sync event
   always @(negedge mclk) begin
      pos <= (pos == 9) ? 0 : pos + 1;
      tx_in_word <= (short_gaps && pos > 5) ? $random(seed) : 32'hBC95B5B5;
      tx_in_k <= (short_gaps && pos > 5) ? 4'h0 : 4'h8;
      tx_in_fill <= !(short_gaps && pos > 5);
   end
   always @(negedge mclk) begin
      if (reset_n && client_loaded === 1'b1) begin
         if (exp_q.size() == 0) check(1, 0);
         else check(client_time, exp_q.pop_front());
      end
      if (reset_n && csu_tx_req === 1'b1) begin
         if (have_req) check(csu_tx_time - last_req, exp_diff);
         last_req = csu_tx_time;
         have_req = 1;
         req_cnt = req_cnt + 1;
      end
      if (tx_k === 4'h8 && tx_word[31:16] === 16'hBCB7 && h1[31:16] === 16'hBCB6 && h2[31:16] === 16'hBCB5) begin
         w = {h2[15:0], h1[15:0], tx_word[15:0]};
         for (i = 0; i < 6; i = i + 1) begin
            g = u_peer.nd_ord(w[47-8*i -: 8]);
            t = {t[34:0], g};
            check(u_peer.nd_char(g), w[47-8*i -: 8]);
         end
         check(t[41:32], 0);
         check(t >= last_syn, 1);
         last_syn = t;
         syn_cnt = syn_cnt + 1;
      end
      if (hist[179:176] === 4'h0) check({tx_k, tx_word}, hist[179:144]);
      hist = {hist[143:0], tx_in_k, tx_in_word};
      h2 = h1;
      h1 = tx_word;
   end
   initial begin
      repeat (3) @(negedge mclk);
      reset_n = 1;
      repeat (4) @(negedge mclk);
      server_enable = 1;
      client_enable = 1;
      method_els = 1;
      csr_accept = 1;
      @(negedge mclk) csr_accept = 0;
      check(csr_notify, 1);
      check({cap_server, cap_client}, 2'h3);
      set_period(3);
      wait_until(0, 3);
      set_period(0);
      n = req_cnt;
      repeat (1000) @(negedge mclk);
      check(req_cnt, n);
      server_enable = 0;
      set_period(1);
      repeat (300) @(negedge mclk);
      check(req_cnt, n);
      server_enable = 1;
      wait_until(0, n + 3);
      for (i = 0; i < 4; i = i + 1) begin
         t = {$random(seed), $random(seed)};
         exp_q.push_back(t);
         csu_rx_time = t;
         csu_rx_valid = 1;
         @(negedge mclk) csu_rx_valid = 0;
         repeat (3) @(negedge mclk);
      end
      for (i = 0; i < 8; i = i + 1) begin
         t = (i == 0) ? 42'h000_0000_0000 : (i == 1) ? 42'h3FF_FFFF_FFFF : {$random(seed), $random(seed)};
         client_enable = (i != 6);
         coding_64b66b = (i == 7);
         if (i < 4) exp_q.push_back(t);
         u_peer.send_set(t, (i == 4) ? 2'h1 : (i == 5) ? 2'h2 : 2'h0);
         repeat (3) @(negedge mclk);
      end
      check(exp_q.size(), 0);
      client_enable = 1;
      coding_64b66b = 0;
      method_els = 0;
      set_period(2);
      wait_until(1, syn_cnt + 2);
      short_gaps = 1;
      n = syn_cnt;
      repeat (600) @(negedge mclk);
      check(syn_cnt, n);
      short_gaps = 0;
      wait_until(1, n + 1);
      coding_64b66b = 1;
      repeat (20) @(negedge mclk);
      n = syn_cnt;
      repeat (600) @(negedge mclk);
      check(syn_cnt, n);
      final_report;
   end
endmodule // clock_sync_codec_tb
bind clock_sync_codec clock_sync_codec_props u_props (.mclk(mclk), .reset_n(reset_n), .server_enable(server_enable),
   .client_enable(client_enable), .method_els(method_els), .coding_64b66b(coding_64b66b), .csr_accept(csr_accept),
   .tx_in_fill(tx_in_fill), .rx_word(rx_word), .rx_k(rx_k), .rx_fill(rx_fill), .tx_word(tx_word), .tx_k(tx_k),
   .csu_tx_req(csu_tx_req), .csu_tx_time(csu_tx_time), .csr_notify(csr_notify), .cap_server(cap_server),
   .cap_client(cap_client), .client_loaded(client_loaded), .rx_fill_out(rx_fill_out));
